/* design/addr_reg_file.sv */
// sixteen-entry address register memory with registered read ports
`timescale 1ns/1ps
module addr_reg_file #(
    parameter int DW    = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // datapath read, writes bypass so back to back ops see fresh values
    input  wire logic [AW-1:0] ra_addr,
    output logic      [DW-1:0] ra_data,
    // software read
    input  wire logic [AW-1:0] rb_addr,
    output logic      [DW-1:0] rb_data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ra_data <= '0;
            rb_data <= '0;
        end else begin
            ra_data <= (we && waddr == ra_addr) ? wdata : mem[ra_addr];
            rb_data <= mem[rb_addr];
        end
    end
endmodule : addr_reg_file

/* design/loop_alu.sv */
// arithmetic update and boundary comparison of one looping operation
`timescale 1ns/1ps
module loop_alu (
    // operation
    input  wire loop_pkg::op_t         op,
    input  wire logic                  post_mode,
    // operands
    input  wire logic [loop_pkg::DW-1:0] src,
    input  wire logic [loop_pkg::DW-1:0] ofs,
    input  wire logic [loop_pkg::DW-1:0] bound,
    // results
    output logic      [loop_pkg::DW-1:0] y,
    output logic      [loop_pkg::DW-1:0] nxt,
    output logic                         hit
);
    import loop_pkg::*;

    // unsigned, wrapping at the word width
    always_comb begin
        case (op)
            OP_INC:  nxt = src + DW'(1);
            OP_DEC:  nxt = src - DW'(1);
            OP_ADD:  nxt = src + ofs;
            OP_SUB:  nxt = src - ofs;
            default: nxt = src;
        endcase
    end

    assign y = post_mode ? nxt : src;

    always_comb begin
        case (op)
            OP_INC, OP_ADD: hit = (y >= bound);
            OP_DEC, OP_SUB: hit = (y <= bound);
            default:        hit = 1'b0;
        endcase
    end
endmodule : loop_alu

/* design/loop_pkg.sv */
// constants, field layout and types of the looping address update unit
package loop_pkg;
    // datapath widths
    localparam int DW  = 16;
    localparam int IW  = 10;
    localparam int RIW = 4;
    localparam int NR  = 16;
    localparam int NB  = 8;
    localparam int NC  = 4;

    // instruction fields
    localparam int F_GRP_LO = 8;
    localparam int F_SUB_LO = 6;
    localparam int F_CC4_LO = 4;
    localparam int F_CC3_LO = 6;
    localparam int F_BB_LO  = 4;
    localparam int F_ADD    = 3;
    localparam int F_R3_LO  = 0;
    localparam int F_R4_LO  = 0;
    localparam logic [1:0] GRP_DECINC = 2'h2;
    localparam logic [1:0] GRP_ADDSUB = 2'h3;
    localparam logic [1:0] SUB_DEC    = 2'h2;
    localparam logic [1:0] SUB_INC    = 2'h3;

    // control word bits
    localparam int CW       = 11;
    localparam int CR_POST  = 4;
    localparam int CR_ABANK = 7;
    localparam int CR_BBANK = 8;
    localparam int CR_ALT   = 10;
    localparam logic [CW-1:0] CTRL_RST = 11'h000;
    localparam logic [IW-1:0] AIR_RST  = 10'h000;
    localparam logic [2:0]    OFS_PORT_A = 3'h3;
    localparam logic [2:0]    OFS_PORT_B = 3'h7;

    // register port map, word offsets
    localparam int PAW = 6;
    localparam logic [PAW-1:0] REG_CTRL = 6'h00;
    localparam logic [PAW-1:0] REG_AIR  = 6'h01;
    localparam logic [PAW-1:0] REG_STAT = 6'h02;
    localparam logic [PAW-1:0] REG_CMP  = 6'h04;
    localparam logic [PAW-1:0] REG_INIT = 6'h08;
    localparam logic [PAW-1:0] REG_OFS  = 6'h10;
    localparam logic [PAW-1:0] REG_ADDR = 6'h20;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_INC  = 3'h1,
        OP_DEC  = 3'h3,
        OP_ADD  = 3'h2,
        OP_SUB  = 3'h6
    } op_t;
endpackage : loop_pkg

/* design/loop_update_unit.sv */
// looping address update unit: decode, register file, update and compare
// How it works
// - sixteen address registers, index 0 to 15
// - eight offsets; index 3, 7 use data
// - four compare and four init registers
// - three-bit index takes top bit from bank bit
// - offset index third bit from offset bank bit
// - output address before or after update
// - boundary reached or passed raises compare output
// - hit with alt bit runs alternate instruction
// - hit with mask bit and alt bit clear reloads from init
// - hit without alt or mask: write result
// - no hit: write result, compare low
// - data select substitutes data port as source
// - add offset; greater or equal is hit
// - add offset uses bank bit for register
// - decrement; less or equal is hit
// - decrement word 10 10 cc rrrr
// - add word 11 cc bb 1 rrr
// - compare output valid one cycle only
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module loop_update_unit (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // instruction and data from the sequencer
    input  wire logic [loop_pkg::IW-1:0]     instr_in,
    input  wire logic                        instr_valid,
    input  wire logic                        data_substitute_sel,
    input  wire logic [loop_pkg::DW-1:0]     data_in,
    // address port and compare
    output logic      [loop_pkg::DW-1:0]     y_addr,
    output logic                             y_valid,
    output logic                             compare_flag_out,
    // register port
    input  wire logic [loop_pkg::PAW-1:0]    reg_addr,
    input  wire logic [loop_pkg::DW-1:0]     reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [loop_pkg::DW-1:0]     reg_rdata
);
    import loop_pkg::*;

    function automatic logic in_blk(input logic [PAW-1:0] a, input logic [PAW-1:0] base, input int n);
        in_blk = ((a >> n) == (base >> n));
    endfunction : in_blk

    // control and storage
    logic [CW-1:0] ctrl_q;
    logic [IW-1:0] air_q;
    logic [DW-1:0] cmp_q  [NC];
    logic [DW-1:0] init_q [NC];
    logic [DW-1:0] ofs_q  [NB];
    logic          last_hit_q;
    logic          last_alt_q;

    // stage 0 decode
    logic [IW-1:0]  ins;
    logic           v0;
    op_t            op0;
    logic [RIW-1:0] ridx0;
    logic [1:0]     cidx0;
    logic [2:0]     bidx0;
    logic [DW-1:0]  ofs0;

    // stage 1 execute
    logic           v1_q;
    op_t            op1_q;
    logic [RIW-1:0] ridx1_q;
    logic [1:0]     cidx1_q;
    logic [DW-1:0]  ofs1_q;
    logic           dsel1_q;
    logic [DW-1:0]  data1_q;
    logic [DW-1:0]  rd_src;
    logic [DW-1:0]  src1;
    logic [DW-1:0]  alu_y;
    logic [DW-1:0]  alu_nxt;
    logic           alu_hit;
    logic           hit1;
    logic           alt_take;
    logic           reinit;
    logic           dp_we;
    logic [DW-1:0]  dp_wdata;

    // memory write arbitration and software read
    logic           sw_we;
    logic           mem_we;
    logic [RIW-1:0] mem_waddr;
    logic [DW-1:0]  mem_wdata;
    logic [DW-1:0]  rb_data;
    logic           rd_mem_q;
    logic [DW-1:0]  rd_q;

    // a hit with the alt bit set replaces the next port word
    // limitation: an alternate word that hits again with the alt bit still set keeps re-running itself
    assign alt_take = v1_q && hit1 && ctrl_q[CR_ALT];
    assign ins      = alt_take ? air_q : instr_in;
    assign v0       = alt_take || instr_valid;

    always_comb begin
        op0   = OP_NONE;
        ridx0 = ins[F_R4_LO +: RIW];
        cidx0 = ins[F_CC4_LO +: 2];
        if (ins[F_GRP_LO +: 2] == GRP_DECINC) begin
            if (ins[F_SUB_LO +: 2] == SUB_DEC) begin
                op0 = OP_DEC;
            end else if (ins[F_SUB_LO +: 2] == SUB_INC) begin
                op0 = OP_INC;
            end
        end else if (ins[F_GRP_LO +: 2] == GRP_ADDSUB) begin
            op0   = ins[F_ADD] ? OP_ADD : OP_SUB;
            cidx0 = ins[F_CC3_LO +: 2];
            ridx0 = {ctrl_q[CR_ABANK], ins[F_R3_LO +: RIW-1]};
        end
    end

    assign bidx0 = {ctrl_q[CR_BBANK], ins[F_BB_LO +: 2]};
    // offset slots 3 and 7 are never read by the datapath; the data port stands in
    assign ofs0  = (bidx0 == OFS_PORT_A || bidx0 == OFS_PORT_B) ? data_in : ofs_q[bidx0];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            v1_q    <= 1'b0;
            op1_q   <= OP_NONE;
            ridx1_q <= '0;
            cidx1_q <= '0;
            ofs1_q  <= '0;
            dsel1_q <= 1'b0;
            data1_q <= '0;
        end else begin
            v1_q    <= v0 && (op0 != OP_NONE);
            op1_q   <= op0;
            ridx1_q <= ridx0;
            cidx1_q <= cidx0;
            ofs1_q  <= ofs0;
            dsel1_q <= data_substitute_sel;
            data1_q <= data_in;
        end
    end

    // address registers; a port write loses to a datapath write in the same cycle
    assign sw_we     = reg_wr && in_blk(reg_addr, REG_ADDR, RIW);
    assign mem_we    = dp_we || sw_we;
    assign mem_waddr = dp_we ? ridx1_q : reg_addr[RIW-1:0];
    assign mem_wdata = dp_we ? dp_wdata : reg_wdata;

    addr_reg_file #(
        .DW    (DW),
        .DEPTH (NR),
        .AW    (RIW)
    ) u_regs (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .ra_addr (ridx0),
        .ra_data (rd_src),
        .rb_addr (reg_addr[RIW-1:0]),
        .rb_data (rb_data)
    );

    assign src1 = dsel1_q ? data1_q : rd_src;

    loop_alu u_alu (
        .op        (op1_q),
        .post_mode (ctrl_q[CR_POST]),
        .src       (src1),
        .ofs       (ofs1_q),
        .bound     (cmp_q[cidx1_q]),
        .y         (alu_y),
        .nxt       (alu_nxt),
        .hit       (alu_hit)
    );

    assign hit1     = v1_q && alu_hit;
    assign reinit   = hit1 && !ctrl_q[CR_ALT] && ctrl_q[cidx1_q];
    assign dp_we    = v1_q;
    // result still goes to the named register even when the source was the port
    assign dp_wdata = reinit ? init_q[cidx1_q] : alu_nxt;

    // address port and compare pulse
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            y_addr <= '0;
        end else if (v1_q) begin
            y_addr <= alu_y;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            y_valid          <= 1'b0;
            compare_flag_out <= 1'b0;
        end else begin
            y_valid          <= v1_q;
            compare_flag_out <= hit1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_hit_q <= 1'b0;
            last_alt_q <= 1'b0;
        end else if (v1_q) begin
            last_hit_q <= hit1;
            last_alt_q <= alt_take;
        end
    end

    // register port writes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RST;
            air_q  <= AIR_RST;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_q <= reg_wdata[CW-1:0];
            end
            if (reg_addr == REG_AIR) begin
                air_q <= reg_wdata[IW-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NC; i++) begin
                cmp_q[i]  <= '0;
                init_q[i] <= '0;
            end
        end else if (reg_wr) begin
            if (in_blk(reg_addr, REG_CMP, 2)) begin
                cmp_q[reg_addr[1:0]] <= reg_wdata;
            end
            if (in_blk(reg_addr, REG_INIT, 2)) begin
                init_q[reg_addr[1:0]] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NB; i++) begin
                ofs_q[i] <= '0;
            end
        end else if (reg_wr && in_blk(reg_addr, REG_OFS, 3)) begin
            ofs_q[reg_addr[2:0]] <= reg_wdata;
        end
    end

    // register port reads, data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_mem_q <= 1'b0;
            rd_q     <= '0;
        end else begin
            rd_mem_q <= reg_rd && in_blk(reg_addr, REG_ADDR, RIW);
            rd_q     <= '0;
            if (reg_rd) begin
                if (reg_addr == REG_CTRL) begin
                    rd_q <= DW'(ctrl_q);
                end else if (reg_addr == REG_AIR) begin
                    rd_q <= DW'(air_q);
                end else if (reg_addr == REG_STAT) begin
                    rd_q <= DW'({last_alt_q, last_hit_q});
                end else if (in_blk(reg_addr, REG_CMP, 2)) begin
                    rd_q <= cmp_q[reg_addr[1:0]];
                end else if (in_blk(reg_addr, REG_INIT, 2)) begin
                    rd_q <= init_q[reg_addr[1:0]];
                end else if (in_blk(reg_addr, REG_OFS, 3)) begin
                    rd_q <= ofs_q[reg_addr[2:0]];
                end
            end
        end
    end

    assign reg_rdata = rd_mem_q ? rb_data : rd_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_loop_exec;
        v1_q ##1 y_valid;
    endsequence

    sequence s_data_substitute_sel_load;
        v0 && (op0 != OP_NONE) && data_substitute_sel;
    endsequence

    a_flag_on_hit: assert property (hit1 |=> compare_flag_out)
        else $error("compare output missed a boundary hit");

    a_flag_one_cycle: assert property (!v1_q |=> !compare_flag_out)
        else $error("compare output high without a looping op");

    a_flag_low_miss: assert property (v1_q && !alu_hit |=> !compare_flag_out)
        else $error("compare output high on a miss");

    a_addr_pre_out: assert property (v1_q && !ctrl_q[CR_POST] |=> y_addr == $past(src1))
        else $error("pre-update address wrong");

    a_addr_post_out: assert property (v1_q && ctrl_q[CR_POST] |-> s_loop_exec ##0 y_addr == $past(alu_nxt))
        else $error("post-update address wrong");

    a_alt_redirect: assert property (v1_q && alu_hit && ctrl_q[CR_ALT] |-> ins == air_q && v0)
        else $error("alternate instruction not taken");

    a_init_reload: assert property (v1_q && alu_hit && !ctrl_q[CR_ALT] && ctrl_q[cidx1_q]
                                    |-> mem_we && mem_wdata == init_q[cidx1_q])
        else $error("reload from init register missing");

    a_alu_writeback: assert property (v1_q && !(alu_hit && !ctrl_q[CR_ALT] && ctrl_q[cidx1_q])
                                      |-> mem_we && mem_waddr == ridx1_q && mem_wdata == alu_nxt)
        else $error("arithmetic result not written back");

    a_data_substitute_sel_source: assert property (s_data_substitute_sel_load |=> src1 == $past(data_in) && ridx1_q == $past(ridx0))
        else $error("data port not used as source");

    a_add_bank: assert property (v0 && op0 == OP_ADD |-> ridx0[RIW-1] == ctrl_q[CR_ABANK])
        else $error("add uses wrong register bank");

    a_add_update: assert property (v1_q && op1_q == OP_ADD |-> alu_nxt == src1 + ofs1_q
                                   && alu_hit == (alu_y >= cmp_q[cidx1_q]))
        else $error("add offset update or compare wrong");

    a_dec_update: assert property (v1_q && op1_q == OP_DEC |-> alu_nxt == src1 - DW'(1)
                                   && alu_hit == (alu_y <= cmp_q[cidx1_q]))
        else $error("decrement update or compare wrong");

    a_dec_decode: assert property (v0 && ins[IW-1 -: 4] == {GRP_DECINC, SUB_DEC} |=> v1_q && op1_q == OP_DEC)
        else $error("decrement word not decoded");

    a_port_offset: assert property (v0 && (bidx0 == OFS_PORT_A || bidx0 == OFS_PORT_B) |=> ofs1_q == $past(data_in))
        else $error("data port not substituted for offset");

    a_stat_track: assert property (v1_q |=> last_hit_q == $past(hit1) && last_alt_q == $past(alt_take))
        else $error("status bits do not follow the last looping op");

    a_no_reinit_alt: assert property (v1_q && ctrl_q[CR_ALT] |-> !reinit)
        else $error("reload taken while alternate execute is on");
endmodule : loop_update_unit

/* verification/loop_update_unit_tb.sv */
// self-checking bench of the looping address update unit
`timescale 1ns/1ps
module loop_update_unit_tb;
    import loop_pkg::*;
    logic           sys_clk;
    logic           arst_n;
    logic [IW-1:0]  instr_in;
    logic           instr_valid;
    logic           data_substitute_sel;
    logic [DW-1:0]  data_in;
    logic [DW-1:0]  y_addr;
    logic           y_valid;
    logic           compare_flag_out;
    logic [PAW-1:0] reg_addr;
    logic [DW-1:0]  reg_wdata;
    logic           reg_wr;
    logic           reg_rd;
    logic [DW-1:0]  reg_rdata;
    int             err_count;
    int             n_checks;

    seq_model i_seq (.sys_clk(sys_clk), .arst_n(arst_n), .instr_in(instr_in), .instr_valid(instr_valid),
        .data_substitute_sel(data_substitute_sel), .data_in(data_in));
    loop_update_unit i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .instr_in(instr_in), .instr_valid(instr_valid),
        .data_substitute_sel(data_substitute_sel), .data_in(data_in), .y_addr(y_addr), .y_valid(y_valid),
        .compare_flag_out(compare_flag_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        sys_clk = 1'b0;
    end
    always #25 sys_clk = ~sys_clk;

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [PAW-1:0] a, input logic [DW-1:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [PAW-1:0] a, input logic [DW-1:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdchk

    // waits for the next result pulse; always advances first so one pulse is never counted twice
    task automatic wait_y(input logic [DW-1:0] ey, input logic eh);
        int k;
        k = 0;
        @(posedge sys_clk);
        #1;
        while (y_valid !== 1'b1 && k < 8) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        chk({15'h0000, y_valid}, 16'h0001);
        chk(y_addr, ey);
        chk({15'h0000, compare_flag_out}, {15'h0000, eh});
    endtask : wait_y

    task automatic run_op(input logic [IW-1:0] w, input logic s, input logic [DW-1:0] d,
                          input logic [DW-1:0] ey, input logic eh);
        i_seq.issue(w, s, d);
        wait_y(ey, eh);
    endtask : run_op

    task automatic t_reset();
        chk({15'h0000, y_valid}, 16'h0000);
        chk({15'h0000, compare_flag_out}, 16'h0000);
        rdchk(REG_CTRL, 16'h0000);
        rdchk(REG_AIR, 16'h0000);
        rdchk(REG_STAT, 16'h0000);
        wr(6'h03, 16'hFFFF);
        rdchk(6'h03, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            wr(REG_ADDR + 6'(i), 16'h1000 + 16'(i));
        end
        for (int i = 0; i < 16; i++) begin
            rdchk(REG_ADDR + 6'(i), 16'h1000 + 16'(i));
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_dec();
        wr(REG_ADDR + 6'h05, 16'h0010);
        wr(REG_CMP + 6'h01, 16'h000E);
        wr(REG_INIT + 6'h01, 16'h0123);
        run_op({2'h2, 2'h2, 2'h1, 4'h5}, 1'b0, 16'h0000, 16'h0010, 1'b0);
        rdchk(REG_ADDR + 6'h05, 16'h000F);
        wr(REG_CTRL, 16'h0012);
        run_op({2'h2, 2'h2, 2'h1, 4'h5}, 1'b0, 16'h0000, 16'h000E, 1'b1);
        @(posedge sys_clk);
        #1;
        chk({14'h0000, y_valid, compare_flag_out}, 16'h0000);
        rdchk(REG_STAT, 16'h0001);
        rdchk(REG_ADDR + 6'h05, 16'h0123);
        $display("test decrement done");
    endtask : t_dec

    task automatic t_add();
        wr(REG_CTRL, 16'h0190);
        wr(REG_ADDR + 6'h0A, 16'hFFF0);
        wr(REG_OFS + 6'h05, 16'h0020);
        wr(REG_OFS + 6'h03, 16'h0001);
        wr(REG_CMP + 6'h02, 16'h0011);
        run_op({2'h3, 2'h2, 2'h1, 1'b1, 3'h2}, 1'b0, 16'h0000, 16'h0010, 1'b0);
        rdchk(REG_ADDR + 6'h0A, 16'h0010);
        rdchk(REG_ADDR + 6'h02, 16'h1002);
        // slot 3 and the substitute both take the data port; unsigned compare makes 8000 a hit
        wr(REG_CTRL, 16'h0080);
        run_op({2'h3, 2'h2, 2'h3, 1'b1, 3'h2}, 1'b1, 16'h8000, 16'h8000, 1'b1);
        rdchk(REG_ADDR + 6'h0A, 16'h0000);
        $display("test add done");
    endtask : t_add

    task automatic t_incsub();
        wr(REG_CTRL, 16'h0000);
        wr(REG_CMP + 6'h03, 16'h1002);
        wr(REG_OFS + 6'h00, 16'h0003);
        run_op({2'h2, 2'h3, 2'h3, 4'h2}, 1'b0, 16'h0000, 16'h1002, 1'b1);
        rdchk(REG_ADDR + 6'h02, 16'h1003);
        run_op({2'h3, 2'h3, 2'h0, 1'b0, 3'h2}, 1'b0, 16'h0000, 16'h1003, 1'b0);
        rdchk(REG_ADDR + 6'h02, 16'h1000);
        $display("test increment subtract done");
    endtask : t_incsub

    task automatic t_alt();
        wr(REG_AIR, {6'h00, 2'h2, 2'h2, 2'h1, 4'h3});
        wr(REG_CMP + 6'h00, 16'hFFFF);
        wr(REG_CTRL, 16'h0401);
        run_op({2'h2, 2'h2, 2'h0, 4'h4}, 1'b0, 16'h0000, 16'h1004, 1'b1);
        wait_y(16'h1003, 1'b0);
        wr(REG_CTRL, 16'h0000);
        rdchk(REG_ADDR + 6'h04, 16'h1003);
        rdchk(REG_ADDR + 6'h03, 16'h1002);
        $display("test alternate done");
    endtask : t_alt

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        err_count = 0;
        n_checks  = 0;
        arst_n    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_dec();
        t_add();
        t_incsub();
        t_alt();
        tally_and_finish();
    end

    // the tests take under 200 cycles; twenty times that means a hang
    initial begin
        #200000;
        err_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : loop_update_unit_tb

/* verification/seq_model.sv */
// behavioural instruction sequencer standing at the far side of the unit
`timescale 1ns/1ps
module seq_model (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    // instruction and data to the unit
    output logic      [loop_pkg::IW-1:0] instr_in,
    output logic                         instr_valid,
    output logic                         data_substitute_sel,
    output logic      [loop_pkg::DW-1:0] data_in
);
    import loop_pkg::*;

    initial begin
        instr_in            = '0;
        instr_valid         = 1'b0;
        data_substitute_sel = 1'b0;
        data_in             = '0;
    end

    // one word per call, never before reset is released
    task automatic issue(input logic [IW-1:0] w, input logic s, input logic [DW-1:0] d);
        while (arst_n !== 1'b1) begin
            @(posedge sys_clk);
        end
        @(posedge sys_clk);
        instr_in            <= w;
        data_substitute_sel <= s;
        data_in             <= d;
        instr_valid         <= 1'b1;
        @(posedge sys_clk);
        instr_valid         <= 1'b0;
        data_substitute_sel <= 1'b0;
        // inverted junk afterwards, so a stale value can never pass for a fresh one
        instr_in            <= ~w;
        data_in             <= ~d;
    endtask : issue
endmodule : seq_model
